/* File: spc_pkg.sv */
// constants and types for the serial port interface configuration block
package spc_pkg;
  // register addresses on the serial port (15-bit instruction address)
  localparam logic [14:0] ADDR_CONFIG_A = 15'h0000;
  localparam logic [14:0] ADDR_CONFIG_B = 15'h0001;
  localparam logic [7:0] CONFIG_A_RESET = 8'h00;
  localparam logic [7:0] CONFIG_B_RESET = 8'h00;
  // config a field positions
  localparam int A_SOFT_RESET = 0;
  localparam int A_BIT_ORDER = 1;
  localparam int A_ADDR_DIR = 2;
  localparam int A_FOUR_WIRE = 3;
  // config b field positions
  localparam int B_AUX_ZERO = 1;
  localparam int B_AUX_ONE = 2;
  localparam int B_RSV_LO = 3;
  localparam int B_RSV_HI = 5;
  localparam int B_STALL = 6;
  localparam int B_SINGLE = 7;
  // reset line index
  localparam int RL_SOFT = 0;
  localparam int RL_AUX_ZERO = 1;
  localparam int RL_AUX_ONE = 2;
  localparam int N_RESETS = 3;
  // bit counters: 16-bit instruction, 8-bit data bytes
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  // clock cycles each reset line stays high
  localparam logic [2:0] RST_CYCLES = 3'h4;
  // clock cycles of chip select high beyond which a stalled transfer ends
  localparam logic [3:0] STALL_LIMIT = 4'hC;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_INSTR = 4'h2,
    ST_DATA = 4'h4,
    ST_DONE = 4'h8
  } spc_state_type;
endpackage

/* File: spc_serial_config.sv */
// serial control port slave with the two interface configuration registers
`timescale 1ns/10ps

module spc_serial_config
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  output logic sdo_o,
  output logic sdo_oe,
  output logic four_wire_enable,
  output logic addr_direction,
  output logic bit_order_select,
  output logic single_transfer_select,
  output logic select_stall_enable,
  output logic self_clear_reset,
  output logic aux_reset_zero,
  output logic aux_reset_one
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    spc_state_type st;
    logic sclk_m;
    logic sclk_s;
    logic sclk_p;
    logic cs_m;
    logic cs_s;
    logic cs_p;
    logic din_m;
    logic din_s;
    logic [15:0] shift;
    logic [3:0] cnt;
    logic rw;
    logic [14:0] addr;
    logic [7:0] rdbyte;
    logic out_bit;
    logic out_en;
    logic four_wire;
    logic addr_dir;
    logic bit_order;
    logic single;
    logic stall;
    logic [2:0] rsv;
    logic [N_RESETS-1:0] rst_on;
    logic [N_RESETS-1:0][2:0] rst_cnt;
    logic [3:0] pause_cnt;
  } spc_regs_type;

  spc_regs_type q;
  spc_regs_type d;
  logic [15:0] nxt_shift;
  logic [7:0] byte_in;
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic byte_done;

  // ----------------------------------------
  // register decode and read-back
  // ----------------------------------------
  function automatic logic is_reg(input logic [14:0] a, input logic [14:0] target);
    is_reg = (a == target);
  endfunction

  function automatic logic [7:0] read_reg(input spc_regs_type r, input logic [14:0] a);
    logic [3:0] low;
    logic [7:0] v;
    low = {r.four_wire, r.addr_dir, r.bit_order, r.rst_on[RL_SOFT]};
    v = 8'h00;
    if (is_reg(a, ADDR_CONFIG_A)) begin
      v = {low[0], low[1], low[2], low[3], low};
    end else if (is_reg(a, ADDR_CONFIG_B)) begin
      v = {r.single, r.stall, r.rsv, r.rst_on[RL_AUX_ONE], r.rst_on[RL_AUX_ZERO], 1'b0};
    end
    read_reg = v;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.sclk_m = sclk;
    d.sclk_s = q.sclk_m;
    d.sclk_p = q.sclk_s;
    d.cs_m = cs_n;
    d.cs_s = q.cs_m;
    d.cs_p = q.cs_s;
    d.din_m = sdio_i;
    d.din_s = q.din_m;
    cs_rise = q.cs_s && !q.cs_p;
    cs_fall = !q.cs_s && q.cs_p;
    sclk_rise = q.sclk_s && !q.sclk_p;
    sclk_fall = !q.sclk_s && q.sclk_p;
    byte_done = (q.st == ST_DATA) && !q.cs_s && sclk_rise && (q.cnt == BYTE_LAST);
    // lsb first shifts in from the top, so the word layout is the same either way
    nxt_shift = q.bit_order ? {q.din_s, q.shift[15:1]} : {q.shift[14:0], q.din_s};
    byte_in = q.bit_order ? nxt_shift[15:8] : nxt_shift[7:0];

    // reset lines count down and self-clear
    for (int i = 0; i < N_RESETS; i++) begin
      if (q.rst_on[i]) begin
        if (q.rst_cnt[i] == 3'h0) begin
          d.rst_on[i] = 1'b0;
        end else begin
          d.rst_cnt[i] = q.rst_cnt[i] - 3'h1;
        end
      end
    end
    // soft reset completion clears the port configuration
    if (q.rst_on[RL_SOFT] && q.rst_cnt[RL_SOFT] == 3'h0) begin
      d.four_wire = 1'b0;
      d.addr_dir = 1'b0;
      d.bit_order = 1'b0;
      d.single = 1'b0;
      d.stall = 1'b0;
      d.rsv = 3'h0;
    end

    // a stalled pause that outlasts the limit ends the transaction
    if (q.st == ST_DATA && q.cs_s) begin
      d.pause_cnt = q.pause_cnt + 4'h1;
      if (q.pause_cnt == STALL_LIMIT) begin
        d.st = ST_IDLE;
      end
    end else begin
      d.pause_cnt = 4'h0;
    end

    // serial transaction; a write later in this process wins over a clear
    if (cs_rise) begin
      d.out_en = 1'b0;
      if (!(q.stall && q.st == ST_DATA && q.cnt == 4'h0)) begin
        d.st = ST_IDLE;
      end
    end else if (cs_fall) begin
      if (q.st == ST_IDLE) begin
        d.st = ST_INSTR;
        d.cnt = 4'h0;
        d.out_en = 1'b0;
      end else if (q.st == ST_DATA && q.rw) begin
        // a stalled read resumes driving the bit already prepared
        d.out_en = 1'b1;
      end
    end else if (!q.cs_s && sclk_rise) begin
      d.shift = nxt_shift;
      case (q.st)
        ST_INSTR: begin
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == INSTR_LAST) begin
            d.rw = nxt_shift[15];
            d.addr = nxt_shift[14:0];
            d.st = ST_DATA;
            d.rdbyte = read_reg(q, nxt_shift[14:0]);
          end
        end
        ST_DATA: begin
          d.cnt = (q.cnt == BYTE_LAST) ? 4'h0 : q.cnt + 4'h1;
          if (q.cnt == BYTE_LAST) begin
            if (!q.rw && is_reg(q.addr, ADDR_CONFIG_A)) begin
              // mirror bits 7..4 are not stored
              d.four_wire = byte_in[A_FOUR_WIRE];
              d.addr_dir = byte_in[A_ADDR_DIR];
              d.bit_order = byte_in[A_BIT_ORDER];
              if (byte_in[A_SOFT_RESET]) begin
                d.rst_on[RL_SOFT] = 1'b1;
                d.rst_cnt[RL_SOFT] = RST_CYCLES - 3'h1;
              end
            end else if (!q.rw && is_reg(q.addr, ADDR_CONFIG_B)) begin
              d.single = byte_in[B_SINGLE];
              d.stall = byte_in[B_STALL];
              d.rsv = byte_in[B_RSV_HI:B_RSV_LO];
              if (byte_in[B_AUX_ONE]) begin
                d.rst_on[RL_AUX_ONE] = 1'b1;
                d.rst_cnt[RL_AUX_ONE] = RST_CYCLES - 3'h1;
              end
              if (byte_in[B_AUX_ZERO]) begin
                d.rst_on[RL_AUX_ZERO] = 1'b1;
                d.rst_cnt[RL_AUX_ZERO] = RST_CYCLES - 3'h1;
              end
            end
            d.addr = q.addr_dir ? q.addr + 15'h1 : q.addr - 15'h1;
            d.rdbyte = read_reg(q, d.addr);
            if (q.single) begin
              d.st = ST_DONE;
              d.out_en = 1'b0;
            end
          end
        end
        ST_IDLE, ST_DONE: begin
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end else if (!q.cs_s && sclk_fall && q.st == ST_DATA && q.rw) begin
      d.out_en = 1'b1;
      d.out_bit = q.bit_order ? q.rdbyte[q.cnt[2:0]] : q.rdbyte[3'h7 - q.cnt[2:0]];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
      q.st <= ST_IDLE;
      // chip select idles high, so its synchroniser does too
      q.cs_m <= 1'b1;
      q.cs_s <= 1'b1;
      q.cs_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sdio_o = q.out_bit;
  assign sdo_o = q.out_bit;
  assign sdio_oe = q.out_en && !q.four_wire;
  assign sdo_oe = q.out_en && q.four_wire;
  assign four_wire_enable = q.four_wire;
  assign addr_direction = q.addr_dir;
  assign bit_order_select = q.bit_order;
  assign single_transfer_select = q.single;
  assign select_stall_enable = q.stall;
  assign self_clear_reset = q.rst_on[RL_SOFT];
  assign aux_reset_zero = q.rst_on[RL_AUX_ZERO];
  assign aux_reset_one = q.rst_on[RL_AUX_ONE];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_mirror_bits: assert property (@(posedge clk) disable iff (!reset_n)
    read_reg(q, ADDR_CONFIG_A) ==
    {self_clear_reset, bit_order_select, addr_direction, four_wire_enable,
     four_wire_enable, addr_direction, bit_order_select, self_clear_reset})
    else $error("config a mirror bits disagree with low bits");

  a_four_wire_pin: assert property (@(posedge clk) disable iff (!reset_n)
    sdo_oe |-> (!sdio_oe && four_wire_enable))
    else $error("read data driven on the wrong pin");

  a_addr_step: assert property (@(posedge clk) disable iff (!reset_n)
    byte_done |=> (q.addr == ($past(q.addr_dir) ? $past(q.addr) + 15'h1
                                                 : $past(q.addr) - 15'h1)))
    else $error("streaming address stepped the wrong way");

  a_bit_order_in: assert property (@(posedge clk) disable iff (!reset_n)
    (sclk_rise && !q.cs_s && q.st == ST_INSTR) |=>
    (($past(q.bit_order) ? q.shift[15] : q.shift[0]) == $past(q.din_s)))
    else $error("input bit entered at the wrong end");

  a_soft_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(self_clear_reset) |-> self_clear_reset[*4] ##1 !self_clear_reset)
    else $error("soft reset line did not self-clear after four cycles");

  a_single_stop: assert property (@(posedge clk) disable iff (!reset_n)
    (byte_done && single_transfer_select && !cs_rise) |=> (q.st == ST_DONE) ##1 !sdio_oe)
    else $error("single transfer mode streamed past one byte");

  a_stall_end: assert property (@(posedge clk) disable iff (!reset_n)
    (cs_rise && !select_stall_enable) |=> (q.st == ST_IDLE))
    else $error("transfer survived chip select with stalling off");

  a_pause_limit: assert property (@(posedge clk) disable iff (!reset_n)
    (q.st == ST_DATA && q.cs_s && q.pause_cnt == STALL_LIMIT) |=> (q.st == ST_IDLE))
    else $error("stalled transfer outlived the pause limit");

  a_resume_drive: assert property (@(posedge clk) disable iff (!reset_n)
    (cs_fall && q.st == ST_DATA && q.rw) |=> (sdio_oe || sdo_oe))
    else $error("resumed read left the data pin undriven");

  a_aux_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(aux_reset_one) |-> aux_reset_one[*4] ##1 !aux_reset_one)
    else $error("auxiliary reset one did not self-clear after four cycles");

  a_reset_zero: assert property (@(posedge clk) disable iff (1'b0)
    !reset_n |=> (read_reg(q, ADDR_CONFIG_A) == CONFIG_A_RESET &&
                  read_reg(q, ADDR_CONFIG_B) == CONFIG_B_RESET && q.st == ST_IDLE))
    else $error("configuration not zero after reset");

endmodule

/* File: spc_host_model.sv */
// spi host model that drives the serial control port
`timescale 1ns/10ps
module spc_host_model (
  input wire logic clk,
  input wire logic lsb,
  input wire logic four,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  output logic sclk = 1'b0,
  output logic cs_n = 1'b1,
  output logic sdio_i,
  output logic rd_valid = 1'b0,
  output logic [7:0] rd_byte = 8'h00
);
  logic drv = 1'b0;
  logic drv_oe = 1'b0;
  // a line that neither host nor device drives shows the inverse of the bit the device holds
  assign sdio_i = drv_oe ? drv : (sdio_oe ? sdio_o : ~sdio_o);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one sclk period, line sampled just before the rising edge
  task automatic bitx(input logic b, output logic r);
    drv <= b;
    tick(8);
    r = four ? (sdo_oe ? sdo_o : ~sdo_o) : sdio_i;
    sclk <= 1'b1;
    tick(8);
    sclk <= 1'b0;
  endtask
  task automatic xfer(input logic rw, input logic [14:0] a, input int n,
                      input logic [15:0] d, input logic stl);
    logic [15:0] w;
    logic [7:0] v;
    logic [7:0] rb;
    logic r;
    w = {rw, a};
    drv_oe <= 1'b1;
    cs_n <= 1'b0;
    tick(8);
    for (int i = 0; i < 16; i++) bitx(lsb ? w[i] : w[15 - i], r);
    drv_oe <= ~rw;
    for (int k = 0; k < n; k++) begin
      v = d[k * 8 +: 8];
      for (int i = 0; i < 8; i++) begin
        bitx(lsb ? v[i] : v[7 - i], r);
        rb[lsb ? i : 7 - i] = r;
      end
      if (rw) begin
        rd_byte <= rb;
        rd_valid <= 1'b1;
        tick(1);
        rd_valid <= 1'b0;
      end
      if (stl && k < n - 1) begin
        cs_n <= 1'b1;
        tick(8);
        cs_n <= 1'b0;
        tick(8);
      end
    end
    tick(4);
    cs_n <= 1'b1;
    drv_oe <= 1'b0;
    tick(8);
  endtask
endmodule

/* File: serial_port_interface_config_tb_top.sv */
// self-checking bench for the serial port interface configuration block
`timescale 1ns/10ps
module serial_port_interface_config_tb_top;
  import spc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic lsb = 1'b0;
  logic four = 1'b0;
  logic sclk, cs_n, sdio_i, sdio_o, sdio_oe, sdo_o, sdo_oe, rd_valid;
  logic fw, ad, bo, st, ss, sr, ax0, ax1;
  logic [7:0] rd_byte, lf;
  logic [7:0] n0 = 8'h00;
  logic [7:0] n1 = 8'h00;
  logic [7:0] n2 = 8'h00;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int compares = 0;
  always #4 clk = ~clk;
  spc_serial_config u_spc_serial_config (.clk(clk), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe), .four_wire_enable(fw), .addr_direction(ad), .bit_order_select(bo),
    .single_transfer_select(st), .select_stall_enable(ss), .self_clear_reset(sr),
    .aux_reset_zero(ax0), .aux_reset_one(ax1));
  spc_host_model u_spc_host_model (.clk(clk), .lsb(lsb), .four(four), .sdio_o(sdio_o),
    .sdio_oe(sdio_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sclk(sclk), .cs_n(cs_n),
    .sdio_i(sdio_i), .rd_valid(rd_valid), .rd_byte(rd_byte));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // reads note their expected bytes, writes carry data
  task automatic op(input logic rw, input logic [14:0] a, input int n,
                    input logic [15:0] d, input logic stl = 1'b0);
    if (rw) exp_q.push_back(d[7:0]);
    if (rw && n > 1) exp_q.push_back(d[15:8]);
    u_spc_host_model.xfer(rw, a, n, d, stl);
    repeat (8) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (reset_n && sr) n0 <= n0 + 8'h01;
    if (reset_n && ax0) n1 <= n1 + 8'h01;
    if (reset_n && ax1) n2 <= n2 + 8'h01;
    if (rd_valid && exp_q.size() == 0) check(rd_byte, 8'hXX);
    if (rd_valid && exp_q.size() > 0) check(rd_byte, exp_q.pop_front());
  end
  initial begin
    lf = 8'h33;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    op(1'b1, ADDR_CONFIG_A, 2, {CONFIG_B_RESET, CONFIG_A_RESET});
    op(1'b1, ADDR_CONFIG_B, 1, {8'h00, CONFIG_B_RESET});
    $display("reset values test done");
    op(1'b0, ADDR_CONFIG_A, 1, 16'h00F4);
    check({5'h00, fw, ad, bo}, 8'h02);
    op(1'b0, ADDR_CONFIG_A, 2, 16'h4024);
    op(1'b1, ADDR_CONFIG_A, 2, 16'h4024);
    op(1'b1, ADDR_CONFIG_A, 2, 16'h4024, 1'b1);
    check({7'h00, ss}, 8'h01);
    op(1'b0, ADDR_CONFIG_A, 1, 16'h0000);
    op(1'b1, ADDR_CONFIG_B, 2, 16'h0040);
    $display("mirror, stream and stall test done");
    op(1'b0, ADDR_CONFIG_A, 1, 16'h0018);
    four <= 1'b1;
    op(1'b1, ADDR_CONFIG_A, 1, 16'h0018);
    op(1'b0, ADDR_CONFIG_A, 1, 16'h0000);
    four <= 1'b0;
    op(1'b0, ADDR_CONFIG_A, 1, 16'h0042);
    lsb <= 1'b1;
    op(1'b1, ADDR_CONFIG_A, 1, 16'h0042);
    op(1'b0, ADDR_CONFIG_A, 1, 16'h0000);
    lsb <= 1'b0;
    $display("four wire and bit order test done");
    op(1'b0, ADDR_CONFIG_B, 2, 16'h0480);
    op(1'b0, ADDR_CONFIG_A, 2, 16'h0000);
    op(1'b1, ADDR_CONFIG_A, 1, 16'h0000);
    check({7'h00, st}, 8'h01);
    op(1'b0, ADDR_CONFIG_B, 1, 16'h0000);
    lf = lfsr(lf);
    op(1'b0, ADDR_CONFIG_B, 1, {8'h00, lf & 8'h39});
    op(1'b1, ADDR_CONFIG_B, 1, {8'h00, lf & 8'h38});
    lf = lfsr(lf);
    op(1'b1, {7'h40, lf}, 1, 16'h0000);
    $display("single, reserved and unmapped test done");
    op(1'b0, ADDR_CONFIG_A, 1, 16'h0025);
    check(n0, {5'h00, RST_CYCLES});
    op(1'b1, ADDR_CONFIG_A, 2, 16'h0000);
    op(1'b0, ADDR_CONFIG_B, 1, 16'h0006);
    check({n2[3:0], n1[3:0]}, {1'b0, RST_CYCLES, 1'b0, RST_CYCLES});
    op(1'b1, ADDR_CONFIG_B, 1, 16'h0000);
    $display("soft reset test done");
    check(8'(exp_q.size()), 8'h00);
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule
